/* rtl/parc_pkg.sv */
// Package of offsets, field positions and reset values for the power and reference control bank
package parc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int          DATA_W            = 16;
    localparam logic [7:0]  IDX_PWR_TUNE      = 8'h1A;
    localparam logic [7:0]  IDX_REF_PROBE     = 8'h1B;
    localparam logic [15:0] RST_PWR_TUNE      = 16'h0020;
    localparam logic [15:0] RST_REF_PROBE     = 16'h0000;
    localparam logic [31:0] UNMAPPED_READ     = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int          POS_OSC_TUNE_HI   = 15;
    localparam int          POS_OSC_TUNE_LO   = 10;
    localparam int          POS_BIAS_SLEEP    = 7;
    localparam int          POS_TEMP_SLEEP    = 6;
    localparam int          POS_MULT_SLEEP    = 5;
    localparam int          POS_RECV_SLEEP    = 4;
    localparam int          POS_EXT_REF       = 15;
    localparam int          POS_FUSE_SLEEP    = 11;
    localparam int          POS_PROBE_HI      = 5;
    localparam int          POS_PROBE_LO      = 0;

    // Writable bits; all others are reserved and hold zero
    localparam logic [15:0] MASK_PWR_TUNE     = 16'hFCF0;
    localparam logic [15:0] MASK_REF_PROBE    = 16'h883F;

    // Bus answer states
    typedef enum logic [1:0] {PARC_IDLE, PARC_ANSWER} parc_bus_state_t;

endpackage

/* rtl/parc_ctrl_reg.sv */
// One 16-bit control register with a write mask and a reset value
`timescale 1ns/1ps
`default_nettype none
module parc_ctrl_reg
    import parc_pkg::*;
#(
    parameter logic [15:0] RESET_VALUE = 16'h0000,
    parameter logic [15:0] WRITE_MASK  = 16'hFFFF
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // Write port
    input  wire logic        writeStrobe,
    input  wire logic [15:0] writeData,
    input  wire logic [1:0]  byteEnable,
    // Stored value
    output logic      [15:0] value
);

    logic [15:0] next_value;
    logic [15:0] laneMask;

    always_comb begin
        laneMask   = {{8{byteEnable[1]}}, {8{byteEnable[0]}}} & WRITE_MASK;
        next_value = value;
        if (writeStrobe) begin
            // Reserved bits never take a written one
            next_value = (value & ~laneMask) | (writeData & laneMask);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            value <= RESET_VALUE;
        end else begin
            value <= next_value;
        end
    end

endmodule
`default_nettype wire

/* rtl/parc_power_ref_ctrl.sv */
// Power, tuning and reference control bank behind an Avalon-MM slave
`timescale 1ns/1ps
`default_nettype none
module parc_power_ref_ctrl
    import parc_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // Avalon-MM slave
    input  wire logic [9:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output logic [1:0]       response,
    // Transmit gate function from the core
    input  wire logic        transmitGateIn,
    // Analogue controls
    output logic [5:0]       oscCoarseTune,
    output logic             biasSleep,
    output logic             tempSensorSleep,
    output logic             multiplierSleep,
    output logic             clockReceiverSleep,
    output logic             syncReferenceInputSleep,
    output logic             externalRefSelect,
    output logic             fuseSleep,
    output logic [5:0]       probeSelect,
    output logic             probeActive,
    // Transmit gate pin
    output logic             transmitGatePinOut,
    output logic             transmitGatePinOe_n
);

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // Byte address is four times the register index
    logic [7:0]      wordIndex;
    logic            hitPwr;
    logic            hitRef;
    logic            mapped;
    parc_bus_state_t busState;
    parc_bus_state_t next_busState;
    logic [31:0]     next_readdata;
    logic [1:0]      next_response;
    logic [15:0]     pwrValue;
    logic [15:0]     refValue;
    logic            pwrWrite;
    logic            refWrite;

    assign wordIndex = address[9:2];
    assign hitPwr    = (wordIndex == IDX_PWR_TUNE);
    assign hitRef    = (wordIndex == IDX_REF_PROBE);
    assign mapped    = hitPwr | hitRef;

    // Every access takes one wait cycle; write lands on the releasing edge
    assign waitrequest = (read | write) && (busState == PARC_IDLE);
    assign pwrWrite    = write && (busState == PARC_ANSWER) && hitPwr;
    assign refWrite    = write && (busState == PARC_ANSWER) && hitRef;

    always_comb begin
        next_busState = PARC_IDLE;
        next_readdata = readdata;
        next_response = response;
        if ((read | write) && (busState == PARC_IDLE)) begin
            next_busState = PARC_ANSWER;
            next_response = mapped ? 2'h0 : 2'h3;
            if (read) begin
                if (hitPwr) begin
                    next_readdata = {16'h0000, pwrValue};
                end else if (hitRef) begin
                    next_readdata = {16'h0000, refValue};
                end else begin
                    next_readdata = UNMAPPED_READ;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            busState <= PARC_IDLE;
            readdata <= 32'h0000_0000;
            response <= 2'h0;
        end else begin
            busState <= next_busState;
            readdata <= next_readdata;
            response <= next_response;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    parc_ctrl_reg #(
        .RESET_VALUE (RST_PWR_TUNE),
        .WRITE_MASK  (MASK_PWR_TUNE)
    ) pwrTuneReg (
        .core_clk    (core_clk),
        .reset_n     (reset_n),
        .writeStrobe (pwrWrite),
        .writeData   (writedata[15:0]),
        .byteEnable  (byteenable[1:0]),
        .value       (pwrValue)
    );

    parc_ctrl_reg #(
        .RESET_VALUE (RST_REF_PROBE),
        .WRITE_MASK  (MASK_REF_PROBE)
    ) refProbeReg (
        .core_clk    (core_clk),
        .reset_n     (reset_n),
        .writeStrobe (refWrite),
        .writeData   (writedata[15:0]),
        .byteEnable  (byteenable[1:0]),
        .value       (refValue)
    );

    // ------------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------------
    assign oscCoarseTune           = pwrValue[POS_OSC_TUNE_HI:POS_OSC_TUNE_LO];
    assign biasSleep               = pwrValue[POS_BIAS_SLEEP];
    assign tempSensorSleep         = pwrValue[POS_TEMP_SLEEP];
    assign multiplierSleep         = pwrValue[POS_MULT_SLEEP];
    // One bit sleeps both receivers together
    assign clockReceiverSleep      = pwrValue[POS_RECV_SLEEP];
    assign syncReferenceInputSleep = pwrValue[POS_RECV_SLEEP];
    assign externalRefSelect       = refValue[POS_EXT_REF];
    // Resets to zero; software is expected to set it during bring-up
    assign fuseSleep               = refValue[POS_FUSE_SLEEP];
    assign probeSelect             = refValue[POS_PROBE_HI:POS_PROBE_LO];
    assign probeActive             = (probeSelect != 6'h00);

    // ------------------------------------------------------------------
    // Transmit gate pin
    // ------------------------------------------------------------------
    // In probe mode the digital driver lets go so the analogue voltage owns the pin
    assign transmitGatePinOut  = probeActive ? 1'b0 : transmitGateIn;
    assign transmitGatePinOe_n = probeActive;

endmodule
`default_nettype wire

/* testbench/parc_power_ref_ctrl_asserts.sv */
// Checker of the power and reference control bank
`timescale 1ns/1ps
`default_nettype none
module parc_power_ref_ctrl_chk
    import parc_pkg::*;
(
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        reset_n,
    // Bus and pin inputs
    input wire logic        read,
    input wire logic        write,
    input wire logic        transmitGateIn,
    input wire logic [9:0]  address,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    // Design outputs
    input wire logic        waitrequest,
    input wire logic        biasSleep,
    input wire logic        tempSensorSleep,
    input wire logic        multiplierSleep,
    input wire logic        clockReceiverSleep,
    input wire logic        syncReferenceInputSleep,
    input wire logic        externalRefSelect,
    input wire logic        fuseSleep,
    input wire logic        probeActive,
    input wire logic        transmitGatePinOut,
    input wire logic        transmitGatePinOe_n,
    input wire logic [5:0]  oscCoarseTune,
    input wire logic [5:0]  probeSelect
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // Edge at which a write completes, per register
    wire logic wPwr = write && !waitrequest && address[9:2] == IDX_PWR_TUNE;
    wire logic wRef = write && !waitrequest && address[9:2] == IDX_REF_PROBE;
    AST_TUNE: assert property (wPwr && byteenable[1] |=>
        oscCoarseTune == $past(writedata[15:10]))
        else $error("coarse tune differs from written value");
    AST_LOW: assert property (wPwr && byteenable[0] |=>
        {biasSleep, tempSensorSleep, multiplierSleep, clockReceiverSleep,
         syncReferenceInputSleep} == {$past(writedata[7:4]), $past(writedata[4])})
        else $error("sleep controls differ from written value");
    AST_MULT: assert property ($rose(reset_n) |-> multiplierSleep)
        else $error("multiplier not asleep after reset");
    AST_EXT: assert property (wRef && byteenable[1] |=>
        externalRefSelect == $past(writedata[15]))
        else $error("reference select differs from written value");
    AST_FUSE: assert property (wRef && byteenable[1] |=>
        fuseSleep == $past(writedata[11]))
        else $error("fuse sleep differs from written value");
    AST_PROBE: assert property (wRef && byteenable[0] |=>
        probeSelect == $past(writedata[5:0]))
        else $error("probe select differs from written value");
    AST_PIN: assert property (probeActive == (probeSelect != 6'h00) &&
        (probeActive ? transmitGatePinOe_n && !transmitGatePinOut
                     : !transmitGatePinOe_n && transmitGatePinOut == transmitGateIn))
        else $error("transmit gate pin wrong for probe state");
    AST_WAIT: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("answer not given after one wait cycle");
    COV_PWR: cover property (wPwr);
    COV_REF: cover property (wRef);
    COV_PROBE: cover property (probeActive && transmitGateIn);
endmodule
bind parc_power_ref_ctrl parc_power_ref_ctrl_chk i_parc_power_ref_ctrl_chk (.*);
`default_nettype wire

/* testbench/parc_power_ref_ctrl_tb_top.sv */
// Self-checking bench of the power and reference control bank
`timescale 1ns/1ps
`default_nettype none
module parc_power_ref_ctrl_tb_top import parc_pkg::*; ;
    localparam logic [9:0] AP = {IDX_PWR_TUNE, 2'b00};
    localparam logic [9:0] AR = {IDX_REF_PROBE, 2'b00};
    logic core_clk = 1'b0, reset_n = 1'b0, read = 1'b0, write = 1'b0, transmitGateIn = 1'b0;
    logic [9:0] address = 10'h000;
    logic [31:0] writedata = 32'h0, readdata, got;
    logic [3:0] byteenable = 4'h0;
    logic [1:0] response, gotResp;
    logic waitrequest, biasSleep, tempSensorSleep, multiplierSleep, clockReceiverSleep;
    logic syncReferenceInputSleep, externalRefSelect, fuseSleep, probeActive;
    logic transmitGatePinOut, transmitGatePinOe_n;
    logic [5:0] oscCoarseTune, probeSelect;
    int bad_count = 0, check_count = 0;
    wire logic [21:0] outs = {oscCoarseTune, biasSleep, tempSensorSleep, multiplierSleep,
        clockReceiverSleep, syncReferenceInputSleep, externalRefSelect, fuseSleep,
        probeSelect, probeActive, transmitGatePinOut, transmitGatePinOe_n};
    parc_power_ref_ctrl i_parc_power_ref_ctrl (.*);
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    // Expected outputs from the two register images and the gate input
    function automatic logic [31:0] expo(input logic [15:0] p, r, input logic g);
        logic a;
        a = r[5:0] != 6'h00;
        expo = {10'h000, p[15:10], p[7:4], p[4], r[15], r[11], r[5:0], a, g & !a, a};
    endfunction
    task automatic cmpData(input logic [31:0] g, e);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %0t value %h expected %h", $time, g, e);
        end
    endtask
    task automatic cmpResp(input logic [1:0] g, e);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %0t response %h expected %h", $time, g, e);
        end
    endtask
    // Request held until waitrequest is seen low, released after that edge
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        @(posedge core_clk);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        byteenable <= be;
        do @(posedge core_clk); while (waitrequest !== 1'b0);
        got = readdata;
        gotResp = response;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] e, input logic [1:0] r);
        bus(1'b0, a, 32'h0, 4'hF);
        cmpData(got, e);
        cmpResp(gotResp, r);
    endtask
    task automatic outChk(input logic [15:0] p, r);
        @(negedge core_clk);
        cmpData({10'h000, outs}, expo(p, r, transmitGateIn));
    endtask
    task automatic doReset();
        reset_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge core_clk);
        bad_count++;
        end_of_test();
    end
    initial begin
        doReset();
        rd(AP, 32'h0000_0020, 2'h0);
        rd(AR, 32'h0000_0000, 2'h0);
        outChk(16'h0020, 16'h0000);
        bus(1'b1, AP, 32'hFFFF_FFFF, 4'hF);
        cmpResp(gotResp, 2'h0);
        rd(AP, 32'h0000_FCF0, 2'h0);
        outChk(16'hFCF0, 16'h0000);
        bus(1'b1, AP, 32'h0000_0000, 4'h1);
        rd(AP, 32'h0000_FC00, 2'h0);
        outChk(16'hFC00, 16'h0000);
        @(posedge core_clk);
        transmitGateIn <= 1'b1;
        bus(1'b1, AR, 32'hFFFF_FFFF, 4'h3);
        rd(AR, 32'h0000_883F, 2'h0);
        outChk(16'hFC00, 16'h883F);
        bus(1'b1, AR, 32'h0000_0800, 4'h3);
        outChk(16'hFC00, 16'h0800);
        @(posedge core_clk);
        transmitGateIn <= 1'b0;
        outChk(16'hFC00, 16'h0800);
        bus(1'b1, 10'h070, 32'h0000_FFFF, 4'h3);
        cmpResp(gotResp, 2'h3);
        rd(10'h070, 32'h0000_0000, 2'h3);
        rd(AR, 32'h0000_0800, 2'h0);
        doReset();
        rd(AP, 32'h0000_0020, 2'h0);
        rd(AR, 32'h0000_0000, 2'h0);
        // Host sets the fuse sleep bit again after this second reset
        bus(1'b1, AR, 32'h0000_0800, 4'h3);
        rd(AR, 32'h0000_0800, 2'h0);
        outChk(16'h0020, 16'h0800);
        end_of_test();
    end
endmodule
`default_nettype wire
